// ### adc_input_mux_select.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module adc_input_mux_select (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             offset_cancel_enable,
    output logic      [21:0] negative_switch,
    output logic      [36:0] positive_switch
);
    import adc_mux_pkg::*;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [31:0] adc_front_end_config;
    bus_state_e  state;
    logic        setup;
    logic        hit_cfg;
    logic        hit_sts;

    assign setup   = psel && !penable;
    assign hit_cfg = (paddr == config_offset);
    assign hit_sts = (paddr == status_offset);

    // answers one cycle after setup: pready high in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= bus_idle;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            case (state)
                bus_idle: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (setup) begin
                        state  <= bus_access;
                        pready <= 1'b1;
                        if (hit_cfg) begin
                            prdata  <= adc_front_end_config;
                        end else if (hit_sts) begin
                            prdata  <= {27'h0, |negative_switch, |positive_switch,
                                        offset_cancel_enable, 2'h0};
                            pslverr <= pwrite;
                        end else begin
                            prdata  <= 32'h0000_0000;
                            pslverr <= 1'b1;
                        end
                    end
                end
                bus_access: begin
                    state   <= bus_idle;
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: state <= bus_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    // masked write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_front_end_config <= config_reset;
        end else if (psel && penable && pready && pwrite && hit_cfg) begin
            adc_front_end_config <= pwdata & config_wmask;
        end
    end

    // ------------------------------------------------------------
    // switch decode
    // ------------------------------------------------------------
    logic [4:0]  negative_input_select;
    logic [5:0]  positive_input_select;
    logic [21:0] next_negative_switch;
    logic [36:0] next_positive_switch;

    assign negative_input_select = adc_front_end_config[neg_sel_lsb +: neg_sel_width];
    assign positive_input_select = adc_front_end_config[pos_sel_lsb +: pos_sel_width];

    // one-hot by code; bit n enables source of code n
    always_comb begin
        next_negative_switch = 22'h0;
        case (negative_input_select)
            5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0b, 5'h0c,
            5'h0e, 5'h10, 5'h11, 5'h14:
                next_negative_switch[negative_input_select] = 1'b1;
            default: next_negative_switch = 22'h0;
        endcase
    end

    always_comb begin
        next_positive_switch = 37'h0;
        case (positive_input_select)
            6'h00, 6'h03, 6'h11, 6'h15, 6'h1c, 6'h20, 6'h22:
                next_positive_switch = 37'h0;
            default: begin
                if (positive_input_select <= 6'h24) begin
                    next_positive_switch[positive_input_select] = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_cancel_enable <= 1'b0;
            negative_switch      <= 22'h0;
            positive_switch      <= 37'h0;
        end else begin
            offset_cancel_enable <= adc_front_end_config[offset_cancel_bit];
            negative_switch      <= next_negative_switch;
            positive_switch      <= next_positive_switch;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_cfg_write;
        psel && penable && pready && pwrite && hit_cfg;
    endsequence

    sequence s_cfg_read;
        psel && penable && pready && !pwrite && hit_cfg;
    endsequence

    a_cancel_follows_bit: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_write |=> ##1 (offset_cancel_enable == $past(pwdata[15], 2)))
        else $error("cancel enable does not follow written bit");
    a_neg_floating_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h00) |=> (negative_switch == 22'h0))
        else $error("negative input not floating on code zero");
    a_neg_tia_fast: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h01) |=> (negative_switch == 22'h000002))
        else $error("negative fast amplifier node not selected");
    a_neg_bias_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h08) |=> negative_switch[8])
        else $error("bias capacitor node not selected");
    a_neg_excite: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h14) |=> negative_switch[20])
        else $error("excitation negative node not selected");
    a_pos_floating_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h00) |=> (positive_switch == 37'h0))
        else $error("positive input not floating on code zero");
    a_pos_filtered_tia: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h02) |=> positive_switch[2])
        else $error("filtered low-power amplifier not selected");
    a_pos_counter_half: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h1f) |=> positive_switch[31])
        else $error("half counter voltage not selected");
    a_pos_excite: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h24) |=> positive_switch[36])
        else $error("excitation positive node not selected");
    a_reserved_no_switch: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select inside {6'h03, 6'h11, 6'h15, 6'h1c, 6'h20, 6'h22}
         || positive_input_select > 6'h24) |=> (positive_switch == 37'h0))
        else $error("reserved code enabled a switch");
    a_reserved_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_read |-> ((prdata & ~config_wmask) == 32'h0))
        else $error("reserved bits read back set");

    a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_write |=> (adc_front_end_config == ($past(pwdata) & config_wmask)))
        else $error("configuration write did not land");
    a_config_readback: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_read |-> (prdata == adc_front_end_config))
        else $error("configuration read data differs");
    a_status_write_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && state == bus_idle && hit_sts && pwrite) |=> pslverr)
        else $error("status write not refused");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && state == bus_idle && !hit_cfg && !hit_sts) |=> (pslverr && prdata == 32'h0))
        else $error("unmapped access not refused");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_neg_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(negative_switch))
        else $error("several negative switches closed");
    a_pos_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(positive_switch))
        else $error("several positive switches closed");
    a_neg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select inside {5'h03, 5'h09, 5'h0a, 5'h0d, 5'h0f, 5'h12, 5'h13}
         || negative_input_select > 5'h14) |=> (negative_switch == 22'h0))
        else $error("reserved negative code enabled a switch");

    // ------------------------------------------------------------
    // negative decode checks
    // ------------------------------------------------------------

    a_neg_tia_low: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h02) |=> negative_switch[2])
        else $error("negative low-power amplifier node not selected");
    a_neg_input_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h04) |=> negative_switch[4])
        else $error("negative analog input 0 not selected");
    a_neg_input_one: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h05) |=> negative_switch[5])
        else $error("negative analog input 1 not selected");
    a_neg_input_two: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h06) |=> negative_switch[6])
        else $error("negative analog input 2 not selected");
    a_neg_input_three: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h07) |=> negative_switch[7])
        else $error("negative analog input 3 not selected");

    a_neg_temp_sensor: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h0b) |=> negative_switch[11])
        else $error("negative sensor output not selected");
    a_neg_input_four: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h0c) |=> negative_switch[12])
        else $error("negative analog input 4 not selected");
    a_neg_input_six: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h0e) |=> negative_switch[14])
        else $error("negative analog input 6 not selected");

    a_neg_zero_bias: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h10) |=> negative_switch[16])
        else $error("negative zero-bias pin not selected");
    a_neg_bias_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (negative_input_select == 5'h11) |=> negative_switch[17])
        else $error("negative bias pin not selected");

    // ------------------------------------------------------------
    // positive decode checks
    // ------------------------------------------------------------

    a_pos_tia_fast: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h01) |=> positive_switch[1])
        else $error("positive fast amplifier signal not selected");
    a_pos_input_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h04) |=> positive_switch[4])
        else $error("positive analog input 0 not selected");
    a_pos_input_one: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h05) |=> positive_switch[5])
        else $error("positive analog input 1 not selected");
    a_pos_input_two: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h06) |=> positive_switch[6])
        else $error("positive analog input 2 not selected");
    a_pos_input_three: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h07) |=> positive_switch[7])
        else $error("positive analog input 3 not selected");
    a_pos_supply_half: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h08) |=> positive_switch[8])
        else $error("positive analog supply half not selected");
    a_pos_digital_half: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h09) |=> positive_switch[9])
        else $error("positive digital supply half not selected");
    a_pos_regulator_half: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h0a) |=> positive_switch[10])
        else $error("positive regulator half not selected");
    a_pos_temp_internal: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h0b) |=> positive_switch[11])
        else $error("positive internal sensor not selected");
    a_pos_bias_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h0c) |=> positive_switch[12])
        else $error("positive bias capacitor node not selected");

    a_pos_drive_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h0d) |=> positive_switch[13])
        else $error("positive drive electrode pin not selected");
    a_pos_sense_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h0e) |=> positive_switch[14])
        else $error("positive sense electrode pin not selected");
    a_pos_pin_three: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h0f) |=> positive_switch[15])
        else $error("positive front-end pin three not selected");
    a_pos_ref_half: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h10) |=> positive_switch[16])
        else $error("positive reference half not selected");
    a_pos_ref_low: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h12) |=> positive_switch[18])
        else $error("positive low reference not selected");

    a_pos_temp_negative: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h13) |=> positive_switch[19])
        else $error("positive sensor negative terminal not selected");
    a_pos_input_four: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h14) |=> positive_switch[20])
        else $error("positive analog input 4 not selected");
    a_pos_input_six: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h16) |=> positive_switch[22])
        else $error("positive analog input 6 not selected");
    a_pos_zero_bias: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h17) |=> positive_switch[23])
        else $error("positive zero-bias pin not selected");
    a_pos_bias_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h18) |=> positive_switch[24])
        else $error("positive bias pin not selected");

    a_pos_counter_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h19) |=> positive_switch[25])
        else $error("positive counter electrode pin not selected");
    a_pos_reference_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h1a) |=> positive_switch[26])
        else $error("positive reference electrode pin not selected");
    a_pos_pin_four: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h1b) |=> positive_switch[27])
        else $error("positive front-end pin four not selected");
    a_pos_pin_one: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h1d) |=> positive_switch[29])
        else $error("positive front-end pin one not selected");
    a_pos_pin_two: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h1e) |=> positive_switch[30])
        else $error("positive front-end pin two not selected");

    a_pos_tia_output: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h21) |=> positive_switch[33])
        else $error("positive low-power amplifier output not selected");
    a_pos_analog_ground: assert property (@(posedge pclk) disable iff (!presetn)
        (positive_input_select == 6'h23) |=> positive_switch[35])
        else $error("positive analog ground not selected");

endmodule : adc_input_mux_select

`default_nettype wire

// ### adc_mux_pkg.sv
package adc_mux_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] config_offset  = 12'h000;
    localparam logic [11:0] status_offset  = 12'h004;
    localparam logic [31:0] config_reset   = 32'h0000_0000;
    localparam logic [31:0] config_wmask   = 32'h0000_9f3f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int offset_cancel_bit = 15;
    localparam int neg_sel_lsb       = 8;
    localparam int neg_sel_width     = 5;
    localparam int pos_sel_lsb       = 0;
    localparam int pos_sel_width     = 6;
    localparam int neg_sources       = 22;
    localparam int pos_sources       = 37;

    // ------------------------------------------------------------
    // bus states of the register slave
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        bus_idle   = 1'b0,
        bus_access = 1'b1
    } bus_state_e;

endpackage : adc_mux_pkg

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define check_eq(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module tb_top;
    import adc_mux_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cancel;
    logic [21:0] neg_sw;
    logic [36:0] pos_sw;
    logic [31:0] rdata;
    logic        rerr;
    int          err_total = 0;
    int          cmp_count = 0;

    // codes that close a switch; all others leave the input floating
    localparam logic [31:0] neg_ok = 32'h0013_59f6;
    localparam logic [63:0] pos_ok = 64'h0000_001a_efdd_fff6;

    adc_input_mux_select dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .offset_cancel_enable (cancel),
        .negative_switch      (neg_sw),
        .positive_switch      (pos_sw)
    );

    always #4 pclk = ~pclk;

    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // apb master: setup, access until pready, then release
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        if (pready !== 1'b1) begin
            err_total++;
            finish_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic outs(input logic [5:0] n, input logic [5:0] p, input logic c);
        logic [21:0] ne;
        logic [36:0] pe;
        ne = neg_ok[n] ? 22'h1 << n : 22'h0;
        pe = pos_ok[p] ? 37'h1 << p : 37'h0;
        @(posedge pclk);
        #1;
        `check_eq("negative_switch", ne, neg_sw)
        `check_eq("positive_switch", pe, pos_sw)
        `check_eq("offset_cancel_enable", c, cancel)
        xfer(1'b0, status_offset, 32'h0);
        `check_eq("status", {|ne, |pe, c}, rdata[4:2])
        `check_eq("status read error", 1'b0, rerr)
    endtask : outs

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        outs(6'h0, 6'h0, 1'b0);
        xfer(1'b0, config_offset, 32'h0);
        `check_eq("config reset", 32'h0000_0000, rdata)
        for (int i = 0; i < 64; i++) begin
            d = {16'hfffb, i[0], 2'b11, i[4:0], 2'b11, i[5:0]};
            xfer(1'b1, config_offset, d);
            `check_eq("config write error", 1'b0, rerr)
            outs({1'b0, i[4:0]}, i[5:0], i[0]);
            xfer(1'b0, config_offset, 32'h0);
            `check_eq("config readback", d & 32'h0000_9f3f, rdata)
        end
        xfer(1'b1, status_offset, 32'hffff_ffff);
        `check_eq("status write error", 1'b1, rerr)
        xfer(1'b0, 12'h008, 32'h0);
        `check_eq("unmapped read error", 1'b1, rerr)
        `check_eq("unmapped read data", 32'h0000_0000, rdata)
        xfer(1'b1, 12'hffc, 32'h0000_0000);
        `check_eq("unmapped write error", 1'b1, rerr)
        outs(6'h1f, 6'h3f, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        `check_eq("switches in reset", 59'h0, {neg_sw, pos_sw})
        `check_eq("cancel in reset", 1'b0, cancel)
        `check_eq("bus in reset", 34'h0, {prdata, pready, pslverr})
        @(posedge pclk);
        presetn <= 1'b1;
        outs(6'h0, 6'h0, 1'b0);
        xfer(1'b0, config_offset, 32'h0);
        `check_eq("config after reset", 32'h0000_0000, rdata)
        finish_test;
    end
endmodule : tb_top

`default_nettype wire
